// ### verilog/psr_status_readback.sv
// Status and telemetry readback: fault byte, vendor status, ADC readings, revision
//
// Notes on behaviour
// RULE_01: Illegal or unsupported command code sets fault byte bit 7.
// RULE_02: Illegal or unsupported data with a command sets fault byte bit 6.
// RULE_03: Surplus byte before stop sets bit 5 unless it is a matching PEC.
// RULE_04: Any EEPROM fault sets fault byte bit 4.
// RULE_05: Fault byte bits 3, 2 and 0 always read zero.
// RULE_06: Other malformed bus transactions set fault byte bit 1.
// RULE_07: Vendor status bits 1:0 are device-wide; bits 7:2 are per page.
// RULE_08: Sticky bits 7,6,5,2 clear only by clear-faults or user channel-on; bit 0 only by clear-faults.
// RULE_09: Vendor bits 7, 6, 5 or 0 set drive the alert line low.
// RULE_10: Discharge fault while entering ON sets vendor bit 7 for that channel.
// RULE_11: Turn-on with fault line low, or shutdown by it, sets bit 6/5.
// RULE_12: Vendor bit 4 live shows servo target reached, no alert.
// RULE_13: Vendor bit 3 live shows trim DAC connected and driving.
// RULE_14: Servo ending at DAC max or min sets sticky vendor bit 2.
// RULE_15: Vendor bit 1 live shows input enable dropped by output fault.
// RULE_16: Watchdog expiry sets sticky, alerting, device-wide vendor bit 0.
// RULE_17: Input voltage reading returns latest input sense sample, linear-11 volts.
// RULE_18: Output reading returns latest channel sample, linear-16 volts.
// RULE_19: Odd channel with high-resolution current returns linear-11 millivolt word.
// RULE_20: Temperature reading returns latest die sensor sample, linear-11 Celsius.
// RULE_21: Revision byte is read-only and always 0x11.
// RULE_22: Host byte-reads status, word-reads telemetry, after selecting the page.
`include "psr_cfg.svh"

module psr_status_readback #(
    parameter int N_CH   = 8,
    parameter int PAGE_W = 3
) (
    input  wire logic                  clk,                 // 250 MHz clock
    input  wire logic                  rstn,                // Async reset, active low
    input  wire logic                  rd_req,              // Read request pulse
    input  wire logic [7:0]            rd_cmd,              // Command code of the read
    input  wire logic [PAGE_W-1:0]     page,                // Selected channel page
    output logic                       rd_valid_q,          // Read answer pulse
    output logic [15:0]                rd_data_q,           // Read data, bytes in low 8
    output logic                       rd_unsup_q,          // Unknown command pulse
    input  wire logic                  cmd_illegal_evt,     // Illegal command from protocol
    input  wire logic                  data_illegal_evt,    // Illegal data from protocol
    input  wire logic                  extra_byte_evt,      // Surplus byte before stop
    input  wire logic                  extra_byte_pec_ok,   // Surplus byte matched PEC
    input  wire logic                  mem_fault_evt,       // EEPROM fault
    input  wire logic                  bus_malformed_evt,   // Other malformed transaction
    input  wire logic                  clear_faults,        // Clear-faults command pulse
    input  wire logic [N_CH-1:0]       chan_user_on,        // User commands channel on
    input  wire logic [N_CH-1:0]       chan_entering_on,    // Channel entering ON state
    input  wire logic [N_CH-1:0]       discharge_fault_evt, // Output discharge fault
    input  wire logic [N_CH-1:0]       chan_turn_on_try,    // Channel tries to turn on
    input  wire logic [N_CH-1:0]       shut_by_line0,       // Shut down by fault line 0
    input  wire logic [N_CH-1:0]       shut_by_line1,       // Shut down by fault line 1
    input  wire logic                  shared_fault_line0_n, // Fault line 0 pin
    input  wire logic                  shared_fault_line1_n, // Fault line 1 pin
    input  wire logic [N_CH-1:0]       servo_at_target,     // Servo target reached
    input  wire logic [N_CH-1:0]       trim_dac_output,     // DAC driving its pin
    input  wire logic [N_CH-1:0]       servo_done_evt,      // Servo operation ended
    input  wire logic [N_CH-1:0]       dac_at_limit,        // DAC code at max or min
    input  wire logic                  vin_en_faulted_off,  // Input enable dropped
    input  wire logic                  watchdog_expired,    // Watchdog expiry pulse
    input  wire logic [N_CH-1:0]       adc_hires,           // High-res current select
    input  wire logic                  adc_wr,              // ADC sample strobe
    input  wire psr_pkg::psr_adc_kind_t adc_kind,           // Kind of the sample
    input  wire logic [PAGE_W-1:0]     adc_ch,              // Channel of the sample
    input  wire logic [15:0]           adc_word,            // Encoded sample word
    output logic                       alert_n_output       // Alert line, active low
);

    // Fault line pins pass two flops first
    logic line0_s1_q;
    logic line0_s2_q;
    logic line1_s1_q;
    logic line1_s2_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line0_s1_q <= 1'b1;
            line0_s2_q <= 1'b1;
            line1_s1_q <= 1'b1;
            line1_s2_q <= 1'b1;
        end else begin
            line0_s1_q <= shared_fault_line0_n;
            line0_s2_q <= line0_s1_q;
            line1_s1_q <= shared_fault_line1_n;
            line1_s2_q <= line1_s1_q;
        end
    end

    // Read decode
    logic known_cmd;
    always_comb begin
        unique case (rd_cmd)
            `PSR_CMD_CML_FAULTS,
            `PSR_CMD_VENDOR_STATUS,
            `PSR_CMD_VIN_READING,
            `PSR_CMD_VOUT_READING,
            `PSR_CMD_TEMP_READING,
            `PSR_CMD_BUS_REVISION: known_cmd = 1'b1;
            default:               known_cmd = 1'b0;
        endcase
    end

    // Communication, memory and logic fault byte
    logic [7:0] cml_q;
    logic [7:0] cml_set;
    logic [7:0] cml_d;

    always_comb begin
        cml_set = 8'h00;
        cml_set[`PSR_CML_CMD_BIT]  = cmd_illegal_evt | (rd_req & ~known_cmd);  // [RULE_01]
        cml_set[`PSR_CML_DATA_BIT] = data_illegal_evt;                         // [RULE_02]
        cml_set[`PSR_CML_PEC_BIT]  = extra_byte_evt & ~extra_byte_pec_ok;      // [RULE_03]
        cml_set[`PSR_CML_MEM_BIT]  = mem_fault_evt;                            // [RULE_04]
        cml_set[`PSR_CML_BUS_BIT]  = bus_malformed_evt;                        // [RULE_06]
        // Set wins over a clear in the same cycle
        cml_d = (clear_faults ? 8'h00 : cml_q) | cml_set;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cml_q <= `PSR_CML_RESET;
        end else begin
            cml_q <= cml_d;
        end
    end

    // Bits 3, 2 and 0 are never stored
    logic [7:0] cml_view;
    assign cml_view = cml_q & 8'hf2;  // [RULE_05]

    // Per-channel sticky vendor bits
    logic [N_CH-1:0] disch_q;
    logic [N_CH-1:0] line1_q;
    logic [N_CH-1:0] line0_q;
    logic [N_CH-1:0] dac_sat_q;
    logic [N_CH-1:0] ch_clr;
    logic [N_CH-1:0] disch_set;
    logic [N_CH-1:0] line1_set;
    logic [N_CH-1:0] line0_set;
    logic [N_CH-1:0] dac_sat_set;

    assign ch_clr      = {N_CH{clear_faults}} | chan_user_on;                          // [RULE_08]
    assign disch_set   = discharge_fault_evt & chan_entering_on;                       // [RULE_10]
    assign line1_set   = (chan_turn_on_try & {N_CH{~line1_s2_q}}) | shut_by_line1;     // [RULE_11]
    assign line0_set   = (chan_turn_on_try & {N_CH{~line0_s2_q}}) | shut_by_line0;     // [RULE_11]
    assign dac_sat_set = servo_done_evt & dac_at_limit;                                // [RULE_14]

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            disch_q   <= '0;
            line1_q   <= '0;
            line0_q   <= '0;
            dac_sat_q <= '0;
        end else begin
            disch_q   <= (disch_q & ~ch_clr) | disch_set;      // [RULE_08]
            line1_q   <= (line1_q & ~ch_clr) | line1_set;      // [RULE_08]
            line0_q   <= (line0_q & ~ch_clr) | line0_set;      // [RULE_08]
            dac_sat_q <= (dac_sat_q & ~ch_clr) | dac_sat_set;  // [RULE_08]
        end
    end

    // Device-wide watchdog flag, cleared only by clear-faults
    logic wdog_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdog_q <= 1'b0;
        end else begin
            wdog_q <= (wdog_q & ~clear_faults) | watchdog_expired;  // [RULE_16]
        end
    end

    // Alert from stored flags only
    logic alert_any;
    assign alert_any = (|disch_q) | (|line1_q) | (|line0_q) | wdog_q;  // [RULE_09]

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            alert_n_output <= 1'b1;
        end else begin
            alert_n_output <= ~alert_any;  // [RULE_09]
        end
    end

    // Vendor status byte for the selected page
    logic [7:0] mfr_view;
    always_comb begin
        mfr_view = 8'h00;
        mfr_view[`PSR_MFR_DISCHARGE_BIT] = disch_q[page];          // [RULE_07]
        mfr_view[`PSR_MFR_LINE1_BIT]     = line1_q[page];
        mfr_view[`PSR_MFR_LINE0_BIT]     = line0_q[page];
        mfr_view[`PSR_MFR_TARGET_BIT]    = servo_at_target[page];  // [RULE_12]
        mfr_view[`PSR_MFR_DAC_ON_BIT]    = trim_dac_output[page];  // [RULE_13]
        mfr_view[`PSR_MFR_DAC_SAT_BIT]   = dac_sat_q[page];
        mfr_view[`PSR_MFR_VINEN_OFF_BIT] = vin_en_faulted_off;     // [RULE_15] [RULE_07]
        mfr_view[`PSR_MFR_WATCHDOG_BIT]  = wdog_q;                 // [RULE_07]
    end

    // Latest ADC samples
    logic [15:0] vin_q;
    logic [15:0] temp_q;
    logic [15:0] vout_q [N_CH];
    logic [15:0] iout_q [N_CH];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vin_q  <= `PSR_WORD_RESET;
            temp_q <= `PSR_WORD_RESET;
        end else if (adc_wr) begin
            if (adc_kind == psr_pkg::PSR_ADC_VIN) begin
                vin_q <= adc_word;   // [RULE_17]
            end
            if (adc_kind == psr_pkg::PSR_ADC_TEMP) begin
                temp_q <= adc_word;  // [RULE_20]
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N_CH; i++) begin
                vout_q[i] <= `PSR_WORD_RESET;
                iout_q[i] <= `PSR_WORD_RESET;
            end
        end else if (adc_wr) begin
            if (adc_kind == psr_pkg::PSR_ADC_VOUT) begin
                vout_q[adc_ch] <= adc_word;  // [RULE_18]
            end
            if (adc_kind == psr_pkg::PSR_ADC_IOUT) begin
                iout_q[adc_ch] <= adc_word;  // [RULE_19]
            end
        end
    end

    // Odd channel in high-resolution mode returns its current word
    logic        use_iout;
    logic [15:0] out_word;
    assign use_iout = page[0] & adc_hires[page];                // [RULE_19]
    assign out_word = use_iout ? iout_q[page] : vout_q[page];   // [RULE_18] [RULE_19]

    // Read answer one cycle after the request; paged data uses the page at request time
    logic [15:0] rd_mux;
    always_comb begin
        unique case (rd_cmd)
            `PSR_CMD_CML_FAULTS:    rd_mux = {8'h00, cml_view};
            `PSR_CMD_VENDOR_STATUS: rd_mux = {8'h00, mfr_view};  // [RULE_22]
            `PSR_CMD_VIN_READING:   rd_mux = vin_q;              // [RULE_17]
            `PSR_CMD_VOUT_READING:  rd_mux = out_word;           // [RULE_18]
            `PSR_CMD_TEMP_READING:  rd_mux = temp_q;             // [RULE_20]
            `PSR_CMD_BUS_REVISION:  rd_mux = {8'h00, `PSR_REV_VALUE};  // [RULE_21]
            default:                rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_valid_q <= 1'b0;
            rd_unsup_q <= 1'b0;
            rd_data_q  <= 16'h0000;
        end else begin
            rd_valid_q <= rd_req;
            rd_unsup_q <= rd_req & ~known_cmd;  // [RULE_01]
            if (rd_req) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_cmd_fault_set: assert property ( // [RULE_01]
        (rd_req && !known_cmd) |=> rd_unsup_q && cml_q[`PSR_CML_CMD_BIT])
        else $error("unknown command did not set bit 7");

    chk_data_fault_set: assert property ( // [RULE_02]
        data_illegal_evt |=> cml_q[`PSR_CML_DATA_BIT])
        else $error("illegal data did not set bit 6");

    chk_pec_fault_rule: assert property ( // [RULE_03]
        (extra_byte_evt && !clear_faults && !cml_q[`PSR_CML_PEC_BIT])
        |=> cml_q[`PSR_CML_PEC_BIT] == !$past(extra_byte_pec_ok))
        else $error("surplus byte handling of bit 5 wrong");

    chk_mem_fault_set: assert property ( // [RULE_04]
        mem_fault_evt |=> cml_q[`PSR_CML_MEM_BIT])
        else $error("memory fault not visible in fault byte");

    chk_reserved_zero: assert property ( // [RULE_05]
        $rose(rd_valid_q) && $past(rd_cmd) == `PSR_CMD_CML_FAULTS
        |-> (rd_data_q & 16'hff0d) == 16'h0000)
        else $error("reserved fault bits not zero");

    chk_bus_fault_set: assert property ( // [RULE_06]
        bus_malformed_evt |=> cml_q[`PSR_CML_BUS_BIT])
        else $error("malformed transaction did not set bit 1");

    chk_sticky_hold: assert property ( // [RULE_08]
        (disch_q[0] && !clear_faults && !chan_user_on[0]) |=> disch_q[0])
        else $error("sticky discharge flag lost without a clear");

    chk_alert_follows: assert property ( // [RULE_09]
        (discharge_fault_evt[0] && chan_entering_on[0]) |-> ##2 !alert_n_output)
        else $error("alert not low two cycles after discharge fault");

    chk_alert_release: assert property ( // [RULE_09]
        !alert_any [*2] |-> alert_n_output)
        else $error("alert held low with no alerting flag");

    chk_watchdog_sticky: assert property ( // [RULE_16]
        watchdog_expired ##1 !clear_faults [*3] |-> wdog_q)
        else $error("watchdog flag not held");

    chk_revision_fixed: assert property ( // [RULE_21]
        (rd_req && rd_cmd == `PSR_CMD_BUS_REVISION) |=> rd_valid_q && rd_data_q == 16'h0011)
        else $error("revision byte not 0x11");

    chk_vin_latest: assert property ( // [RULE_17]
        (adc_wr && adc_kind == psr_pkg::PSR_ADC_VIN) ##1
        (rd_req && rd_cmd == `PSR_CMD_VIN_READING && !adc_wr)
        |=> rd_data_q == $past(adc_word, 2))
        else $error("input voltage reading not the latest sample");

    chk_hires_select: assert property ( // [RULE_19]
        (rd_req && rd_cmd == `PSR_CMD_VOUT_READING && page[0] && adc_hires[page])
        |=> rd_data_q == $past(iout_q[page]))
        else $error("odd hires channel not returning current word");

    chk_unsup_zero: assert property ( // [RULE_01]
        (rd_req && !known_cmd) |=> rd_data_q == 16'h0000)
        else $error("unknown command did not read zero");

    chk_disch_set: assert property ( // [RULE_10]
        (discharge_fault_evt[3] && chan_entering_on[3]) |=> disch_q[3])
        else $error("discharge fault did not set bit 7");

    chk_line0_try: assert property ( // [RULE_11]
        (chan_turn_on_try[4] && !line0_s2_q) |=> line0_q[4])
        else $error("fault line 0 flag not set");

    chk_line1_shut: assert property ( // [RULE_11]
        shut_by_line1[4] |=> line1_q[4])
        else $error("fault line 1 flag not set");

    chk_dac_sat_set: assert property ( // [RULE_14]
        (servo_done_evt[6] && dac_at_limit[6]) |=> dac_sat_q[6])
        else $error("DAC limit flag not set");

    chk_live_bits: assert property ( // [RULE_12] [RULE_13]
        (rd_req && rd_cmd == `PSR_CMD_VENDOR_STATUS)
        |=> rd_data_q[4:3] == $past({servo_at_target[page], trim_dac_output[page]}))
        else $error("live servo and DAC bits wrong");

    chk_shared_bits: assert property ( // [RULE_07] [RULE_15]
        (rd_req && rd_cmd == `PSR_CMD_VENDOR_STATUS)
        |=> rd_data_q[1:0] == $past({vin_en_faulted_off, wdog_q}))
        else $error("device-wide status bits wrong");

    chk_vout_latest: assert property ( // [RULE_18]
        (adc_wr && adc_kind == psr_pkg::PSR_ADC_VOUT) ##1
        (rd_req && rd_cmd == `PSR_CMD_VOUT_READING && !adc_wr &&
         page == $past(adc_ch) && !adc_hires[page])
        |=> rd_data_q == $past(adc_word, 2))
        else $error("output reading not the latest sample");

    chk_temp_latest: assert property ( // [RULE_20]
        (adc_wr && adc_kind == psr_pkg::PSR_ADC_TEMP) ##1
        (rd_req && rd_cmd == `PSR_CMD_TEMP_READING && !adc_wr)
        |=> rd_data_q == $past(adc_word, 2))
        else $error("temperature reading not the latest sample");

    cov_alert_drop: cover property ($fell(alert_n_output));
    cov_pec_ok_byte: cover property (extra_byte_evt && extra_byte_pec_ok);
    cov_set_on_clear: cover property (clear_faults && |cml_set);
    cov_hires_read: cover property (rd_req && rd_cmd == `PSR_CMD_VOUT_READING && use_iout);

endmodule // psr_status_readback

// ### verilog/psr_cfg.svh
// Command codes, field positions and fixed values of the status and telemetry readback block
`ifndef PSR_CFG_SVH
`define PSR_CFG_SVH

// Command codes decoded on the read port (byte reads for status and revision, word reads for the readings)
`define PSR_CMD_CML_FAULTS     8'h40
`define PSR_CMD_VENDOR_STATUS  8'h41
`define PSR_CMD_VIN_READING    8'h42
`define PSR_CMD_VOUT_READING   8'h43
`define PSR_CMD_TEMP_READING   8'h44
`define PSR_CMD_BUS_REVISION   8'h45

// Fault byte bit positions
`define PSR_CML_CMD_BIT        7
`define PSR_CML_DATA_BIT       6
`define PSR_CML_PEC_BIT        5
`define PSR_CML_MEM_BIT        4
`define PSR_CML_BUS_BIT        1

// Vendor status bit positions
`define PSR_MFR_DISCHARGE_BIT  7
`define PSR_MFR_LINE1_BIT      6
`define PSR_MFR_LINE0_BIT      5
`define PSR_MFR_TARGET_BIT     4
`define PSR_MFR_DAC_ON_BIT     3
`define PSR_MFR_DAC_SAT_BIT    2
`define PSR_MFR_VINEN_OFF_BIT  1
`define PSR_MFR_WATCHDOG_BIT   0

// Fixed and reset values
`define PSR_REV_VALUE          8'h11
`define PSR_CML_RESET          8'h00
`define PSR_WORD_RESET         16'h0000

`endif

// ### verilog/psr_pkg.sv
// Types shared by the status and telemetry readback block
package psr_pkg;
    typedef enum logic [1:0] {
        PSR_ADC_VIN,
        PSR_ADC_VOUT,
        PSR_ADC_IOUT,
        PSR_ADC_TEMP
    } psr_adc_kind_t;
endpackage

// ### bench/psr_host_model.sv
// Host model issuing command reads on the read port of the readback block
module psr_host_model #(
    parameter int PAGE_W = 3
) (
    input  wire logic              clk,        // Device clock
    output logic                   rd_req,     // Read request
    output logic [7:0]             rd_cmd,     // Command code
    output logic [PAGE_W-1:0]      page,       // Channel page
    input  wire logic              rd_valid_q, // Answer strobe
    input  wire logic [15:0]       rd_data_q,  // Answer data
    input  wire logic              rd_unsup_q  // Unknown command flag
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rd_req = 1'h0;
        rd_cmd = 8'h00;
        page   = '0;
    end

    // One read; code and page are inverted once released so stale values never match
    task automatic read(input logic [7:0] c, input logic [PAGE_W-1:0] p,
                        output logic [15:0] d, output logic u, output bit to);
        int n;
        to = 1'b1;
        d  = 16'h0000;
        u  = 1'h0;
        @(negedge clk);
        rd_req = 1'h1;
        rd_cmd = c;
        page   = p;
        @(negedge clk);
        rd_req = 1'h0;
        rd_cmd = ~c;
        page   = ~p;
        for (n = 0; n < 4; n++) begin
            if (rd_valid_q === 1'b1) begin
                d  = rd_data_q;
                u  = rd_unsup_q;
                to = 1'b0;
                break;
            end
            @(negedge clk);
        end
    endtask
endmodule // psr_host_model

// ### bench/psr_status_readback_tb.sv
// Self-checking bench of the status and telemetry readback block
`include "psr_cfg.svh"
module psr_status_readback_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic                   wr;
        psr_pkg::psr_adc_kind_t kind;
        logic [2:0]             ch;
        logic [15:0]            word;
        logic [7:0]             hires;
        logic [7:0]             cmd;
        logic [2:0]             pg;
        logic [15:0]            exp;
    } psr_row_t;

    logic clk, rstn, rd_req, rd_valid_q, rd_unsup_q, alert_n_output, last_unsup;
    logic [7:0]  rd_cmd;
    logic [2:0]  page, adc_ch;
    logic [15:0] rd_data_q, adc_word, d, e;
    logic cmd_illegal_evt, data_illegal_evt, extra_byte_evt, extra_byte_pec_ok;
    logic mem_fault_evt, bus_malformed_evt, clear_faults, vin_en_faulted_off;
    logic watchdog_expired, adc_wr, shared_fault_line0_n, shared_fault_line1_n;
    logic [7:0] chan_user_on, chan_entering_on, discharge_fault_evt, chan_turn_on_try;
    logic [7:0] shut_by_line0, shut_by_line1, servo_at_target, trim_dac_output;
    logic [7:0] servo_done_evt, dac_at_limit, adc_hires;
    psr_pkg::psr_adc_kind_t adc_kind;
    int err_count = 0;
    int checks = 0;
    int i;

    psr_row_t rows [6] = '{
        '{1'h1, psr_pkg::PSR_ADC_VIN, 3'h0, 16'h1234, 8'h00, `PSR_CMD_VIN_READING, 3'h0, 16'h1234},
        '{1'h1, psr_pkg::PSR_ADC_VOUT, 3'h2, 16'h2222, 8'hff,
            `PSR_CMD_VOUT_READING, 3'h2, 16'h2222},
        '{1'h1, psr_pkg::PSR_ADC_VOUT, 3'h1, 16'h5555, 8'h00,
            `PSR_CMD_VOUT_READING, 3'h1, 16'h5555},
        '{1'h1, psr_pkg::PSR_ADC_IOUT, 3'h1, 16'h7777, 8'h02,
            `PSR_CMD_VOUT_READING, 3'h1, 16'h7777},
        '{1'h1, psr_pkg::PSR_ADC_TEMP, 3'h0, 16'hc0de, 8'h00,
            `PSR_CMD_TEMP_READING, 3'h0, 16'hc0de},
        '{1'h0, psr_pkg::PSR_ADC_VIN, 3'h0, 16'h0000, 8'h00,
            `PSR_CMD_BUS_REVISION, 3'h3, 16'h0011}
    };

    psr_status_readback u_dut (
        .clk, .rstn, .rd_req, .rd_cmd, .page, .rd_valid_q, .rd_data_q, .rd_unsup_q,
        .cmd_illegal_evt, .data_illegal_evt, .extra_byte_evt, .extra_byte_pec_ok,
        .mem_fault_evt, .bus_malformed_evt, .clear_faults, .chan_user_on, .chan_entering_on,
        .discharge_fault_evt, .chan_turn_on_try, .shut_by_line0, .shut_by_line1,
        .shared_fault_line0_n, .shared_fault_line1_n, .servo_at_target, .trim_dac_output,
        .servo_done_evt, .dac_at_limit, .vin_en_faulted_off, .watchdog_expired, .adc_hires,
        .adc_wr, .adc_kind, .adc_ch, .adc_word, .alert_n_output
    );

    psr_host_model #(.PAGE_W(3)) u_host (
        .clk, .rd_req, .rd_cmd, .page, .rd_valid_q, .rd_data_q, .rd_unsup_q
    );

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] c, input logic [2:0] p, output logic [15:0] q);
        bit to;
        u_host.read(c, p, q, last_unsup, to);
        if (to) begin
            err_count++;
            complete_run();
        end
    endtask

    // One-cycle pulse of event k on channel ch
    task automatic ev(input int k, input int ch);
        @(negedge clk);
        case (k)
            0: cmd_illegal_evt = 1'h1;
            1: data_illegal_evt = 1'h1;
            2: extra_byte_evt = 1'h1;
            3: {extra_byte_evt, extra_byte_pec_ok} = 2'h3;
            4: mem_fault_evt = 1'h1;
            5: bus_malformed_evt = 1'h1;
            6: clear_faults = 1'h1;
            7: watchdog_expired = 1'h1;
            8: {chan_entering_on[ch], discharge_fault_evt[ch]} = 2'h3;
            9: chan_turn_on_try[ch] = 1'h1;
            10: shut_by_line1[ch] = 1'h1;
            11: chan_user_on[ch] = 1'h1;
            default: {servo_done_evt[ch], dac_at_limit[ch]} = 2'h3;
        endcase
        @(negedge clk);
        {cmd_illegal_evt, data_illegal_evt, extra_byte_evt, extra_byte_pec_ok} = 4'h0;
        {mem_fault_evt, bus_malformed_evt, clear_faults, watchdog_expired} = 4'h0;
        {chan_entering_on, discharge_fault_evt, chan_turn_on_try} = 24'h000000;
        {shut_by_line1, chan_user_on, servo_done_evt, dac_at_limit} = 32'h00000000;
    endtask

    initial begin
        rstn = 1'h0;
        {cmd_illegal_evt, data_illegal_evt, extra_byte_evt, extra_byte_pec_ok} = 4'h0;
        {mem_fault_evt, bus_malformed_evt, clear_faults, watchdog_expired, adc_wr} = 5'h00;
        {chan_user_on, chan_entering_on, discharge_fault_evt, chan_turn_on_try} = 32'h0;
        {shut_by_line0, shut_by_line1, servo_at_target, trim_dac_output} = 32'h0;
        {servo_done_evt, dac_at_limit, adc_hires} = 24'h000000;
        {vin_en_faulted_off, shared_fault_line0_n, shared_fault_line1_n} = 3'h3;
        adc_kind = psr_pkg::PSR_ADC_VIN;
        {adc_ch, adc_word} = 19'h00000;
        repeat (4) @(negedge clk);
        check("alert in reset", {15'h0000, alert_n_output}, 16'h0001);
        check("valid in reset", {15'h0000, rd_valid_q}, 16'h0000);
        rstn = 1'h1;
        for (i = 0; i < 6; i++) begin
            adc_hires = rows[i].hires;
            if (rows[i].wr === 1'b1) begin
                @(negedge clk);
                adc_kind = rows[i].kind;
                {adc_wr, adc_ch, adc_word} = {1'h1, rows[i].ch, rows[i].word};
                fork
                    begin
                        @(negedge clk);
                        adc_wr = 1'h0;
                    end
                join_none
            end
            rd(rows[i].cmd, rows[i].pg, d);
            check("row", d, rows[i].exp);
            check("row unsup", {15'h0000, last_unsup}, 16'h0000);
        end
        for (i = 0; i < 6; i++) begin
            ev(i, 0);
            rd(`PSR_CMD_CML_FAULTS, 3'h0, d);
            e = (i == 3) ? 16'h0000 : 16'h0080 >> i - (i > 2) + 2 * (i > 4);
            check("fault byte", d, e);
            ev(6, 0);
            rd(`PSR_CMD_CML_FAULTS, 3'h0, d);
            check("fault byte cleared", d, 16'h0000);
        end
        rd(8'h7f, 3'h0, d);
        check("unknown data", d, 16'h0000);
        check("unknown flag", {15'h0000, last_unsup}, 16'h0001);
        rd(`PSR_CMD_CML_FAULTS, 3'h0, d);
        check("unknown sets bit7", d, 16'h0080);
        ev(6, 0);
        ev(7, 0);
        @(negedge clk);
        check("watchdog alert", {15'h0000, alert_n_output}, 16'h0000);
        repeat (20) @(negedge clk);
        rd(`PSR_CMD_VENDOR_STATUS, 3'h0, d);
        check("watchdog page0", d, 16'h0001);
        rd(`PSR_CMD_VENDOR_STATUS, 3'h5, d);
        check("watchdog page5", d, 16'h0001);
        ev(6, 0);
        @(negedge clk);
        check("alert after clear", {15'h0000, alert_n_output}, 16'h0001);
        ev(8, 3);
        @(negedge clk);
        check("discharge alert", {15'h0000, alert_n_output}, 16'h0000);
        rd(`PSR_CMD_VENDOR_STATUS, 3'h3, d);
        check("discharge page3", d, 16'h0080);
        rd(`PSR_CMD_VENDOR_STATUS, 3'h2, d);
        check("discharge page2", d, 16'h0000);
        ev(11, 3);
        @(negedge clk);
        check("alert after user on", {15'h0000, alert_n_output}, 16'h0001);
        shared_fault_line0_n = 1'h0;
        repeat (3) @(negedge clk);
        ev(9, 4);
        shared_fault_line0_n = 1'h1;
        ev(10, 4);
        rd(`PSR_CMD_VENDOR_STATUS, 3'h4, d);
        check("fault line bits", d, 16'h0060);
        ev(6, 0);
        {servo_at_target[6], trim_dac_output[6], vin_en_faulted_off} = 3'h7;
        ev(12, 6);
        rd(`PSR_CMD_VENDOR_STATUS, 3'h6, d);
        check("live bits", d, 16'h001e);
        check("no alert on live", {15'h0000, alert_n_output}, 16'h0001);
        {servo_at_target[6], trim_dac_output[6], vin_en_faulted_off} = 3'h0;
        rd(`PSR_CMD_VENDOR_STATUS, 3'h6, d);
        check("saturation sticky", d, 16'h0004);
        complete_run();
    end
endmodule // psr_status_readback_tb
